// ---- src/servo_input_conditioner_regs.svh ----
/*
  servo_input_conditioner_regs.svh
  Holds register indices, field positions, reset values and timing counts
  for the servo input conditioner.
  Assumes word-wide Wishbone access; byte address = index * 4.
*/
`ifndef SERVO_INPUT_CONDITIONER_REGS_SVH
`define SERVO_INPUT_CONDITIONER_REGS_SVH

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define IDX_SERVO_INPUT_ENABLE   16'hffce
`define IDX_SERVO_INPUT_CTRL1    16'hffee
`define IDX_SYNC_CONTROL         16'hffef
`define IDX_CAPSTAN_MASK         16'hfff0
`define IDX_TRACK_DRUM_DIVIDER   16'hfff1
`define IDX_CAPSTAN_DIVIDER      16'hfff2
`define IDX_PIN_LEVEL            16'hfff7
`define IDX_INT_STATUS           16'hfff8
`define IDX_INT_MASK             16'hfff9
`define IDX_SERVO_FLAG_RESET     16'hfffe
`define IDX_SERVO_STATUS2        16'hffff

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define EN_DRUM_SPEED_BIT        0
`define EN_DRUM_PHASE_BIT        1
`define EN_CAPSTAN_BIT           2
`define EN_TRACK_BIT             3
`define EN_EXT_BIT               4
`define EN_CSYNC_BIT             5
`define EXT_EDGE_SELECT_BIT      2
`define TRACK_POLARITY_BIT       5
`define MASK_COUNT_LSB           4
`define MALFUNCTION_BIT          0
`define FLAG_RESET_CAPSTAN_BIT   0
`define SOFT_CAPTURE_BIT         1
`define INT_CAPSTAN_BIT          0
`define INT_TRACK_BIT            1
`define INT_CAPTURE_BIT          2
`define INT_MALFUNCTION_BIT      3

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define RST_SERVO_INPUT_ENABLE   6'h00
`define RST_BYTE                 8'h00
`define RST_INT                  4'h0

// -----------------------------------------------------------------------------
// timing: time-base tap period is 2^9 system clocks
// -----------------------------------------------------------------------------
`define TB_TAP_BITS              9

`endif

// ---- src/servo_input_conditioner_pkg.sv ----
/*
  servo_input_conditioner_pkg.sv
  Holds the types shared by the servo input conditioner and its bench.
  Assumes nothing beyond a SystemVerilog tool.
*/
package servo_input_conditioner_pkg;

  // shaped servo pins, all synchronous to the system clock
  typedef struct packed {
    logic csync;
    logic external_trigger;
    logic tape_control_track;
    logic capstan_tach;
    logic drum_phase_pulse;
    logic drum_speed_pulse;
  } servo_pins_s;

  // conditioned signals toward timers, capture and sync logic
  typedef struct packed {
    logic csync_level;          // to sync processing
    logic track_level;          // timer 3 clock and cue detector
    logic capstan_level;        // gated capstan tach level
    logic drum_phase_level;
    logic drum_speed_level;
    logic capstan_divided;      // one pulse per n+1 accepted tach pulses
    logic track_divided;        // one pulse per n+1 track edges
    logic capture_event;        // external trigger or software capture
  } servo_out_s;

  typedef logic [4:0] ratio_t;

endpackage

// ---- src/servo_input_conditioner.sv ----
/*
  servo_input_conditioner.sv
  Servo input conditioner: capstan tach divider with mask window and
  malfunction flag, tape control-track polarity and divider, composite-sync
  gate, external trigger edge select with software capture, interrupt
  status/mask, classic Wishbone register slave.
  Assumes pins already shaped to logic levels and synchronous to clk_in.
*/
`timescale 1ns/100ps
`include "servo_input_conditioner_regs.svh"

module servo_input_conditioner
  import servo_input_conditioner_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [17:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire servo_pins_s pins_in,
  output servo_out_s       servo_out,
  output logic             irq_out
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [5:0]                  input_enable_reg;
  logic [7:0]                  input_ctrl1_reg;
  logic [7:0]                  sync_control_reg;
  logic [7:0]                  capstan_mask_reg;
  logic [7:0]                  track_drum_divider_reg;
  logic [7:0]                  capstan_divider_reg;
  logic                        malfunction_reg;
  logic [3:0]                  int_status_reg;
  logic [3:0]                  int_mask_reg;
  logic                        ack_reg;
  logic [31:0]                 rd_data_reg;
  logic [`TB_TAP_BITS-1:0]     tb_cnt_reg;
  logic [3:0]                  mask_cnt_reg;
  servo_pins_s                 pins_prev_reg;
  logic                        track_prev_reg;
  servo_out_s                  out_reg;
  servo_out_s                  out_next;

  logic                        bus_req;
  logic                        bus_write;
  logic [15:0]                 reg_idx;
  logic                        time_base_tap;
  logic                        capstan_gated;
  logic                        capstan_edge;
  logic                        mask_active;
  logic                        capstan_accept;
  logic                        capstan_malfunction;
  logic                        track_gated;
  logic                        track_level;
  logic                        track_edge;
  logic                        ext_gated;
  logic                        ext_prev_gated;
  logic                        ext_edge;
  logic                        soft_capture;
  logic                        capstan_flag_reset;
  logic                        capture_event;
  logic [1:0]                  div_in;
  logic [1:0]                  div_out;
  ratio_t                      div_ratio [2];
  logic [3:0]                  int_events;
  logic [3:0]                  int_clear;

  // ---------------------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------------------
  // request accepted while ack is low; write lands on the acknowledge edge
  assign bus_req   = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign bus_write = wb_cyc_in & wb_stb_in & ack_reg & wb_we_in & wb_sel_in[0];
  assign reg_idx   = wb_adr_in[17:2];

  // single-cycle acknowledge, dropped the cycle after
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // read data captured with the request, unmapped indices read zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (bus_req) begin
      case (reg_idx)
        `IDX_SERVO_INPUT_ENABLE: rd_data_reg <= {26'h000_0000, input_enable_reg};
        `IDX_SERVO_INPUT_CTRL1:  rd_data_reg <= {24'h00_0000, input_ctrl1_reg};
        `IDX_SYNC_CONTROL:       rd_data_reg <= {24'h00_0000, sync_control_reg};
        `IDX_CAPSTAN_MASK:       rd_data_reg <= {24'h00_0000, capstan_mask_reg};
        `IDX_TRACK_DRUM_DIVIDER: rd_data_reg <= {24'h00_0000, track_drum_divider_reg};
        `IDX_CAPSTAN_DIVIDER:    rd_data_reg <= {24'h00_0000, capstan_divider_reg};
        `IDX_PIN_LEVEL:          rd_data_reg <= {26'h000_0000, pins_in};
        `IDX_INT_STATUS:         rd_data_reg <= {28'h000_0000, int_status_reg};
        `IDX_INT_MASK:           rd_data_reg <= {28'h000_0000, int_mask_reg};
        `IDX_SERVO_STATUS2:      rd_data_reg <= {31'h0000_0000, malfunction_reg};
        default:                 rd_data_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rd_data_reg;

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  // software-written configuration, all zero after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      input_enable_reg       <= `RST_SERVO_INPUT_ENABLE;
      input_ctrl1_reg        <= `RST_BYTE;
      sync_control_reg       <= `RST_BYTE;
      capstan_mask_reg       <= `RST_BYTE;
      track_drum_divider_reg <= `RST_BYTE;
      capstan_divider_reg    <= `RST_BYTE;
      int_mask_reg           <= `RST_INT;
    end else if (bus_write) begin
      case (reg_idx)
        `IDX_SERVO_INPUT_ENABLE: input_enable_reg       <= wb_dat_in[5:0];
        `IDX_SERVO_INPUT_CTRL1:  input_ctrl1_reg        <= wb_dat_in[7:0];
        `IDX_SYNC_CONTROL:       sync_control_reg       <= wb_dat_in[7:0];
        `IDX_CAPSTAN_MASK:       capstan_mask_reg       <= wb_dat_in[7:0];
        `IDX_TRACK_DRUM_DIVIDER: track_drum_divider_reg <= wb_dat_in[7:0];
        `IDX_CAPSTAN_DIVIDER:    capstan_divider_reg    <= wb_dat_in[7:0];
        `IDX_INT_MASK:           int_mask_reg           <= wb_dat_in[3:0];
        default:                 int_mask_reg           <= int_mask_reg;
      endcase
    end
  end

  // write-one pulses from the flag-reset register
  assign capstan_flag_reset = bus_write && reg_idx == `IDX_SERVO_FLAG_RESET
                              && wb_dat_in[`FLAG_RESET_CAPSTAN_BIT];
  assign soft_capture       = bus_write && reg_idx == `IDX_SERVO_FLAG_RESET
                              && wb_dat_in[`SOFT_CAPTURE_BIT];

  // ---------------------------------------------------------------------------
  // input gating and edge detection
  // ---------------------------------------------------------------------------
  // previous pin levels for edge detection
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pins_prev_reg  <= '0;
      track_prev_reg <= 1'b0;
    end else begin
      pins_prev_reg  <= pins_in;
      track_prev_reg <= track_level;
    end
  end

  // enable bit low passes the pin, high forces it inactive
  assign capstan_gated  = pins_in.capstan_tach & ~input_enable_reg[`EN_CAPSTAN_BIT];
  assign capstan_edge   = capstan_gated & ~pins_prev_reg.capstan_tach;
  assign track_gated    = pins_in.tape_control_track & ~input_enable_reg[`EN_TRACK_BIT];
  assign track_level    = track_gated ^ sync_control_reg[`TRACK_POLARITY_BIT];
  assign track_edge     = track_level & ~track_prev_reg;
  assign ext_gated      = pins_in.external_trigger & ~input_enable_reg[`EN_EXT_BIT];
  assign ext_prev_gated = pins_prev_reg.external_trigger & ~input_enable_reg[`EN_EXT_BIT];
  // edge select: 0 rising, 1 falling
  assign ext_edge       = input_ctrl1_reg[`EXT_EDGE_SELECT_BIT] ? (~ext_gated & ext_prev_gated)
                                                                : (ext_gated & ~ext_prev_gated);
  assign capture_event  = ext_edge | soft_capture;

  // ---------------------------------------------------------------------------
  // time base and capstan mask window
  // ---------------------------------------------------------------------------
  // free-running tap, one tick every 2^9 clocks
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tb_cnt_reg <= '0;
    end else begin
      tb_cnt_reg <= tb_cnt_reg + 1'b1;
    end
  end

  assign time_base_tap       = &tb_cnt_reg;
  assign mask_active         = |mask_cnt_reg;
  assign capstan_accept      = capstan_edge & ~mask_active;
  assign capstan_malfunction = capstan_edge & mask_active;

  // mask counter reloads on each accepted pulse, counts down on the tap
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mask_cnt_reg <= 4'h0;
    end else if (capstan_accept) begin
      mask_cnt_reg <= capstan_mask_reg[`MASK_COUNT_LSB +: 4]; // zero leaves masking off
    end else if (time_base_tap && mask_active) begin
      mask_cnt_reg <= mask_cnt_reg - 4'h1;
    end
  end

  // malfunction flag, a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      malfunction_reg <= 1'b0;
    end else if (capstan_malfunction) begin
      malfunction_reg <= 1'b1;
    end else if (capstan_flag_reset) begin
      malfunction_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // programmable dividers: 0 capstan, 1 control track
  // ---------------------------------------------------------------------------
  assign div_in[0]    = capstan_accept;
  assign div_in[1]    = track_edge;
  assign div_ratio[0] = capstan_divider_reg[4:0];
  assign div_ratio[1] = track_drum_divider_reg[4:0];

  generate
    for (genvar i = 0; i < 2; i++) begin : g_div
      logic [4:0] cnt_reg;
      // one output per n+1 input pulses; ratio 0 passes every pulse
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          cnt_reg <= 5'h00;
        end else if (div_in[i]) begin
          cnt_reg <= (cnt_reg >= div_ratio[i]) ? 5'h00 : cnt_reg + 5'h01;
        end
      end
      assign div_out[i] = div_in[i] & (cnt_reg >= div_ratio[i]);
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // conditioned outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    out_next                  = '0;
    out_next.csync_level      = pins_in.csync & ~input_enable_reg[`EN_CSYNC_BIT];
    out_next.track_level      = track_level;
    out_next.capstan_level    = capstan_gated;
    out_next.drum_phase_level = pins_in.drum_phase_pulse & ~input_enable_reg[`EN_DRUM_PHASE_BIT];
    out_next.drum_speed_level = pins_in.drum_speed_pulse & ~input_enable_reg[`EN_DRUM_SPEED_BIT];
    out_next.capstan_divided  = div_out[0];
    out_next.track_divided    = div_out[1];
    out_next.capture_event    = capture_event;
  end

  // outputs registered one clock behind the pins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign servo_out = out_reg;

  // ---------------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------------
  assign int_events = {capstan_malfunction, capture_event, div_out[1], div_out[0]};
  assign int_clear  = (bus_write && reg_idx == `IDX_INT_STATUS) ? wb_dat_in[3:0] : 4'h0;

  // sticky status, write one to clear, set wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_status_reg <= `RST_INT;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clear) | int_events;
    end
  end

  assign irq_out = |(int_status_reg & int_mask_reg);

endmodule // servo_input_conditioner

// ---- verification/servo_pin_source.sv ----
/*
  servo_pin_source.sv: shaped servo pulse source for the conditioner's pins.
  Assumes the bench calls its tasks; all changes land just after a rising clk_in edge.
*/
`timescale 1ns/100ps
module servo_pin_source
  import servo_input_conditioner_pkg::*;
(
  input  wire logic   clk_in,
  output servo_pins_s pins_out
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // pins idle low, as the sense amps leave them
  initial pins_out = '0;
  // one pulse on pin idx: high for hi cycles, then low for lo cycles (lo >= 1 keeps edges apart)
  task automatic pulse(input int idx, input int hi, input int lo);
    @(posedge clk_in);
    pins_out[idx] <= 1'b1;
    repeat (hi) @(posedge clk_in);
    pins_out[idx] <= 1'b0;
    repeat (lo) @(posedge clk_in);
  endtask
  // set one pin to a level
  task automatic level(input int idx, input logic v);
    @(posedge clk_in);
    pins_out[idx] <= v;
  endtask
  // set all pins at once
  task automatic drive_all(input servo_pins_s v);
    @(posedge clk_in);
    pins_out <= v;
  endtask
endmodule // servo_pin_source

// ---- verification/servo_input_conditioner_checker.sv ----
/*
  servo_input_conditioner_checker.sv: port-level assertions for the conditioner.
  Assumes a bind onto servo_input_conditioner; one clock, clk_in.
*/
`timescale 1ns/100ps
`include "servo_input_conditioner_regs.svh"
module servo_input_conditioner_checker
  import servo_input_conditioner_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire servo_pins_s pins_in,
  input wire servo_out_s  servo_out,
  input wire logic        irq_out
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // software capture write, at the edge that takes it
  logic sw_capture;
  // register request taken at this edge
  logic bus_take;
  assign bus_take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign sw_capture = wb_ack_out && wb_we_in && wb_sel_in[0] && wb_dat_in[`SOFT_CAPTURE_BIT]
                      && (wb_adr_in[17:2] == `IDX_SERVO_FLAG_RESET);
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=> servo_out == '0 && !irq_out)
    else $error("outputs not quiet after reset");
  a_ack_answers: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("register request not acknowledged next cycle");
  a_ack_has_cause: assert property (wb_ack_out |-> $past(bus_take))
    else $error("acknowledge without request");
  a_capstan_gate_level: assert property (servo_out.capstan_level |-> $past(pins_in.capstan_tach))
    else $error("capstan level high with pin low");
  a_csync_gate_level: assert property (servo_out.csync_level |-> $past(pins_in.csync))
    else $error("sync level high with pin low");
  a_capstan_edge_only: assert property (servo_out.capstan_divided |-> $past(pins_in.capstan_tach)
                                        && !$past(pins_in.capstan_tach, 2))
    else $error("capstan divided pulse without rising tach edge");
  a_track_pulse_short: assert property (servo_out.track_divided |=> !servo_out.track_divided)
    else $error("track divided pulse longer than one cycle");
  a_capture_cause: assert property (servo_out.capture_event |-> $past(sw_capture)
                                    || $past(pins_in.external_trigger) != $past(pins_in.external_trigger, 2))
    else $error("capture event without trigger edge or software request");
  c_capstan_div: cover property (servo_out.capstan_divided);
  c_capture: cover property (servo_out.capture_event);
  c_irq: cover property (irq_out);
endmodule // servo_input_conditioner_checker
bind servo_input_conditioner servo_input_conditioner_checker chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pins_in(pins_in), .servo_out(servo_out),
  .irq_out(irq_out));

// ---- verification/servo_input_conditioner_tb.sv ----
/*
  servo_input_conditioner_tb.sv: self-checking bench with Wishbone master and pulse source.
  Assumes the design package, register header and servo_pin_source model.
*/
`timescale 1ns/100ps
`include "servo_input_conditioner_regs.svh"
module servo_input_conditioner_tb
  import servo_input_conditioner_pkg::*;
;
  logic        clk_in     = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wb_cyc_in  = 1'b0;
  logic        wb_stb_in  = 1'b0;
  logic        wb_we_in   = 1'b0;
  logic [17:0] wb_adr_in  = '0;
  logic [3:0]  wb_sel_in  = 4'h0;
  logic [31:0] wb_dat_in  = '0;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        irq_out;
  logic [31:0] rd;
  servo_pins_s pins;
  servo_out_s  sout;
  int          mismatches = 0;
  int          compares   = 0;
  int          cycles     = 0;
  int          cap_seen, trk_seen, cpt_seen, p;
  int          ratios[4] = '{0, 1, 4, 31};
  int          masks[3]  = '{0, 1, 15};
  logic [15:0] regs[9]   = '{`IDX_SERVO_INPUT_ENABLE, `IDX_SERVO_INPUT_CTRL1, `IDX_SYNC_CONTROL,
    `IDX_CAPSTAN_MASK, `IDX_TRACK_DRUM_DIVIDER, `IDX_CAPSTAN_DIVIDER, `IDX_INT_STATUS,
    `IDX_INT_MASK, `IDX_SERVO_STATUS2};
  // ----------------------------------------
  // instances, clock, observers
  // ----------------------------------------
  servo_input_conditioner dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pins_in(pins),
    .servo_out(sout), .irq_out(irq_out));
  servo_pin_source src (.clk_in(clk_in), .pins_out(pins));
  always #4 clk_in = ~clk_in;
  // count output pulses; a run-away cycle count ends the run
  always @(posedge clk_in) begin
    cap_seen += (sout.capstan_divided === 1'b1);
    trk_seen += (sout.track_divided === 1'b1);
    cpt_seen += (sout.capture_event === 1'b1);
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("ERROR %0t run did not finish", $time);
      final_report();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= {idx, 2'b00};
    wb_sel_in <= 4'hf;
    wb_dat_in <= {24'h00_0000, d};
    k = 0;
    while (wb_ack_out !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    check(32'(k < 20), 32'h0000_0001);
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(rd, {24'h00_0000, exp});
  endtask
  task automatic do_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cap_seen = 0;
    trk_seen = 0;
    cpt_seen = 0;
  endtask
  task automatic final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9f30_1f81));
    do_reset();
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    rdchk(16'h0100, 8'h00);
    p = $urandom_range(63);
    wb(1'b1, `IDX_SERVO_INPUT_ENABLE, 8'(p));
    rdchk(`IDX_SERVO_INPUT_ENABLE, 8'(p));
    // both dividers over boundary ratios
    foreach (ratios[i]) begin
      for (int t = 0; t < 2; t++) begin
        do_reset();
        wb(1'b1, t ? `IDX_TRACK_DRUM_DIVIDER : `IDX_CAPSTAN_DIVIDER, 8'(ratios[i]));
        p = 2 * (ratios[i] + 1) + $urandom_range(ratios[i]);
        repeat (p) src.pulse(t ? 3 : 2, $urandom_range(1, 3), $urandom_range(1, 3));
        repeat (3) @(posedge clk_in);
        check(t ? trk_seen : cap_seen, p / (ratios[i] + 1));
      end
    end
    // inverted track polarity
    do_reset();
    wb(1'b1, `IDX_SYNC_CONTROL, 8'h20); // polarity switched while the track pin is low and idle
    for (int v = 0; v < 2; v++) begin
      src.level(3, v[0]);
      repeat (3) @(posedge clk_in);
      check(32'(sout.track_level), 32'(!v[0]));
    end
    // enable gating while pins stay readable
    do_reset();
    src.drive_all(6'h3f);
    wb(1'b1, `IDX_SERVO_INPUT_ENABLE, 8'h3f);
    repeat (3) @(posedge clk_in);
    check(32'(sout[7:3]), 32'h0000_0000);
    rdchk(`IDX_PIN_LEVEL, 8'h3f);
    wb(1'b1, `IDX_SERVO_INPUT_ENABLE, 8'h00);
    repeat (3) @(posedge clk_in);
    check(32'(sout[7:3]), 32'h0000_001f);
    src.drive_all(6'h00);
    // mask window, malfunction flag, interrupt raise, mask and clear
    foreach (masks[i]) begin
      do_reset();
      wb(1'b1, `IDX_INT_MASK, 8'h08);
      wb(1'b1, `IDX_CAPSTAN_MASK, 8'(masks[i] << 4));
      src.pulse(2, 1, 1);
      repeat ((masks[i] > 0) ? (masks[i] - 1) * 512 : 0) @(posedge clk_in);
      src.pulse(2, 1, 1);
      repeat (masks[i] * 512 + 8) @(posedge clk_in);
      src.pulse(2, 1, 3);
      check(cap_seen, (masks[i] > 0) ? 2 : 3);
      rdchk(`IDX_SERVO_STATUS2, 8'(masks[i] > 0));
      check(32'(irq_out), 32'(masks[i] > 0));
      wb(1'b1, `IDX_SERVO_FLAG_RESET, 8'h01);
      rdchk(`IDX_SERVO_STATUS2, 8'h00);
      wb(1'b1, `IDX_INT_STATUS, 8'h0f);
      // the clear lands on the acknowledge edge; look once it has settled
      @(posedge clk_in);
      check(32'(irq_out), 32'h0000_0000);
    end
    // external trigger edges and software capture
    for (int s = 0; s < 2; s++) begin
      do_reset();
      wb(1'b1, `IDX_SERVO_INPUT_CTRL1, s ? 8'h04 : 8'h00);
      src.level(4, 1'b1);
      repeat (3) @(posedge clk_in);
      check(cpt_seen, s ? 0 : 1);
      src.level(4, 1'b0);
      repeat (3) @(posedge clk_in);
      check(cpt_seen, 1);
      wb(1'b1, `IDX_SERVO_FLAG_RESET, 8'h02);
      repeat (2) @(posedge clk_in);
      check(cpt_seen, 2);
      rdchk(`IDX_INT_STATUS, 8'h04);
    end
    wb(1'b1, `IDX_SERVO_INPUT_ENABLE, 8'h10);
    src.pulse(4, 2, 3);
    check(cpt_seen, 2);
    final_report();
  end
endmodule // servo_input_conditioner_tb
